// >>> pkg/frame_pkg.sv
// Shared constants and types for the frame generator
package frame_pkg;
   // Clock and sample timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int SAMPLE_PERIOD_NS = 100;
   localparam int SAMPLE_DIV = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TENTH_TIME_US = 102400;
   localparam int SAMPLES_PER_TENTH = TENTH_TIME_US * 1000 / SAMPLE_PERIOD_NS;
   localparam int PAIRS_PER_TENTH = 125;
   localparam int SAMPLES_PER_PAIR = SAMPLES_PER_TENTH / PAIRS_PER_TENTH;
   localparam int TENTHS_PER_FRAME = 10;
   localparam int SAMPLE_IDX_W = 24;
   // Frame layout, zero-based byte positions
   localparam int FRAME_BYTES = 5082;
   localparam int BLOCK_BYTES = 508;
   localparam int LAST_BLOCK_BYTES = FRAME_BYTES - (TENTHS_PER_FRAME - 1) * BLOCK_BYTES;
   localparam int ID_POS = 0;
   localparam int STATUS_POS = 3;
   localparam int RAD_POS = 6;
   localparam int TAG_POS = 21;
   localparam int FIELD_STRIDE = 3;
   localparam int RAD_BYTES = 5;
   localparam int TAG_BYTES = 3;
   localparam int RT_SLOTS = RAD_BYTES + TAG_BYTES;
   localparam logic [7:0] FRAME_ID = 8'hB7;
   localparam int STATUS_SEL_LSB = 4;
   // Test signal figures
   localparam int ADC_WIDTH = 12;
   localparam int IMPULSE_LEN = 2;
   localparam logic signed [15:0] IMPULSE_VALUE = 16'sh0080;
   localparam logic signed [15:0] SQUARE_AMPL = 16'sh0100;
   localparam int SQ_LOW_BIT = 13;
   localparam int SQ_MID_BIT = 8;
   localparam int SQ_HIGH_BIT = 6;
   localparam int LFSR_W = 23;
   localparam logic [LFSR_W-1:0] LFSR_SEED = 23'h000001;
   localparam int LFSR_TAP = 17;
   // Register map
   localparam int APB_ADDR_W = 8;
   localparam logic [APB_ADDR_W-1:0] CTRL_ADDR = 8'h00;
   localparam logic [APB_ADDR_W-1:0] STATUS_ADDR = 8'h04;
   localparam logic [APB_ADDR_W-1:0] TAG_ADDR = 8'h08;
   localparam logic [APB_ADDR_W-1:0] FRAMES_ADDR = 8'h0C;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_SEL_LSB = 4;
   localparam int STATUS_RUNNING_BIT = 0;
   localparam int STATUS_ARMED_BIT = 1;
   localparam logic [2:0] SELECT_RESET = 3'h0;

   typedef enum logic [2:0] {
      SEL_ADC = 3'h0, SEL_IMPULSE = 3'h1, SEL_SQ_LOW = 3'h2, SEL_SQ_MID = 3'h3,
      SEL_PRN_UNIT = 3'h4, SEL_PRN_FULL = 3'h5, SEL_SQ_HIGH = 3'h6, SEL_ZERO = 3'h7
   } select_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1, ST_ARMED = 3'h2, ST_RUNNING = 3'h4
   } run_state_t;
endpackage

// >>> rtl/frame_generator.sv
// Output frame generator: timing, radiometry, time tags, byte interleaving, APB registers
//
// How it works
// - Start on first strobe after enable
// - One frame every 1.024 seconds
// - Frame is exactly 5082 bytes
// - Frames follow each other until switched off
// - First byte is constant B7
// - Fourth byte holds selection in bits 6:4
// - Nonzero selection substitutes a test signal
// - Code 001: two 128 samples, then zeros
// - Codes 010/011/110: three square waves
// - Codes 100/101: unit and full-scale noise
// - Code 000 passes converter, 111 gives zeros
// - Sum of squares, cleared each frame
// - Ten 40-bit radiometry values, MSB first
// - Snapshot every tenth, first at frame start
// - Ten tags per frame, zero at each start, not cleared per frame
// - 24-bit tag, MSB first, wraps
// - 1250 signed 16-bit I/Q pairs
// - Mix 2.5 MHz to baseband and filter
// - All multi-byte values interleaved
// - Radiometry at byte 7, stride 3, block 508
// - Tag at byte 22, stride 3, block 508
// - I/Q bytes fill all remaining positions
//
// Design decisions made here: the APB interface to the registers and the register addresses.
module frame_generator
   import frame_pkg::*;
#(
   parameter int SAMPLES_PER_PAIR_P = SAMPLES_PER_PAIR,
   parameter int ADC_W = ADC_WIDTH
)(
   input wire logic clk_in,                      // System clock, 250 MHz
   input wire logic rst_in,                      // Async reset, high
   input wire logic psel_in,                     // APB select
   input wire logic penable_in,                  // APB enable
   input wire logic pwrite_in,                   // APB write
   input wire logic [APB_ADDR_W-1:0] paddr_in,   // APB byte address
   input wire logic [31:0] pwdata_in,            // APB write data
   output logic [31:0] prdata_out,               // APB read data
   output logic pready_out,                      // APB ready
   output logic pslverr_out,                     // APB error, unmapped address
   input wire logic second_pulse_strobe_in,      // Once-per-second strobe pin
   input wire logic [ADC_W-1:0] adc_data_in,     // Converter word pin bus
   output logic [7:0] frame_data_out,            // Frame byte
   output logic frame_valid_out,                 // Byte strobe
   output logic frame_first_out,                 // Marks the first byte of a frame
   output logic running_out                      // Frames are being produced
);
   localparam int PAIR_CW = $clog2(SAMPLES_PER_PAIR_P);

   logic ctrl_enable, enable_prev;
   logic [2:0] ctrl_select, frame_select;
   run_state_t state;
   logic strobe_meta, strobe_sync, strobe_prev, strobe_rise;
   logic [ADC_W-1:0] adc_meta, adc_sync;
   logic go, running;
   logic apb_setup, apb_write, addr_hit;
   logic [31:0] read_mux;
   logic [4:0] div_cnt;
   logic sample_en;
   logic [PAIR_CW-1:0] samp_in_pair;
   logic [6:0] pair_cnt;
   logic [3:0] tenth_cnt;
   logic [SAMPLE_IDX_W-1:0] samp_idx;
   logic tenth_first, frame_first, pair_last, frame_last;
   logic signed [15:0] sample;
   logic [31:0] square;
   logic [39:0] rad_acc, rad_snap;
   logic [23:0] tag_cnt, tag_snap;
   logic [3:0] snap_count;
   logic [31:0] frame_count;
   logic signed [15:0] dc_i, dc_q, pair_i, pair_q;
   logic dc_valid, pair_full;
   logic em_active;
   logic [3:0] blk;
   logic [8:0] off, rel;
   logic [1:0] iq_byte;
   logic [2:0] slot;
   logic is_id, is_status, is_rt, is_iq, byte_ready, block_end;
   logic [7:0] byte_mux, iq_mux;

   assign running = (state == ST_RUNNING);

   // Pin inputs pass two flops before use
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         strobe_meta <= 1'b0;
         strobe_sync <= 1'b0;
         strobe_prev <= 1'b0;
         adc_meta <= '0;
         adc_sync <= '0;
      end else begin
         strobe_meta <= second_pulse_strobe_in;
         strobe_sync <= strobe_meta;
         strobe_prev <= strobe_sync;
         adc_meta <= adc_data_in;
         adc_sync <= adc_meta;
      end
   end
   assign strobe_rise = strobe_sync & ~strobe_prev;

   // APB slave, no wait states: answer registered in the setup cycle
   assign apb_setup = psel_in & ~penable_in;
   assign apb_write = psel_in & penable_in & pready_out & pwrite_in;
   assign addr_hit = (paddr_in == CTRL_ADDR) || (paddr_in == STATUS_ADDR) ||
                     (paddr_in == TAG_ADDR) || (paddr_in == FRAMES_ADDR);

   always_comb begin
      read_mux = 32'h00000000;
      if (paddr_in == CTRL_ADDR) begin
         read_mux[CTRL_ENABLE_BIT] = ctrl_enable;
         read_mux[CTRL_SEL_LSB +: 3] = ctrl_select;
      end else if (paddr_in == STATUS_ADDR) begin
         read_mux[STATUS_RUNNING_BIT] = running;
         read_mux[STATUS_ARMED_BIT] = (state == ST_ARMED);
      end else if (paddr_in == TAG_ADDR) begin
         read_mux = {8'h00, tag_cnt};
      end else if (paddr_in == FRAMES_ADDR) begin
         read_mux = frame_count;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h00000000;
      end else begin
         pready_out <= apb_setup;
         pslverr_out <= apb_setup & ~addr_hit;
         prdata_out <= (apb_setup && !pwrite_in) ? read_mux : 32'h00000000;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_enable <= 1'b0;
         ctrl_select <= SELECT_RESET;
      end else if (apb_write && paddr_in == CTRL_ADDR) begin
         ctrl_enable <= pwdata_in[CTRL_ENABLE_BIT];
         ctrl_select <= pwdata_in[CTRL_SEL_LSB +: 3];
      end
   end

   assign go = (state == ST_ARMED) && ctrl_enable && strobe_rise;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= ST_IDLE;
         enable_prev <= 1'b0;
         running_out <= 1'b0;
      end else begin
         enable_prev <= ctrl_enable;
         unique case (state)
            ST_IDLE: begin
               if (ctrl_enable && !enable_prev) begin
                  state <= ST_ARMED;
               end
            end
            ST_ARMED: begin
               if (!ctrl_enable) begin
                  state <= ST_IDLE;
               end else if (strobe_rise) begin
                  state <= ST_RUNNING;
               end
            end
            ST_RUNNING: begin
               if (!ctrl_enable) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
         running_out <= (state == ST_RUNNING) ? ctrl_enable : go;
      end
   end

   // 10 MHz sample enable, aligned to the starting strobe
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         div_cnt <= 5'h00;
         sample_en <= 1'b0;
      end else if (go || !running) begin
         div_cnt <= 5'h00;
         sample_en <= 1'b0;
      end else begin
         div_cnt <= (div_cnt == 5'(SAMPLE_DIV - 1)) ? 5'h00 : div_cnt + 5'h01;
         sample_en <= (div_cnt == 5'(SAMPLE_DIV - 1));
      end
   end

   // Frame = 10 tenths x 125 pairs x pair period
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         samp_in_pair <= '0;
         pair_cnt <= 7'h00;
         tenth_cnt <= 4'h0;
         samp_idx <= '0;
      end else if (go) begin
         samp_in_pair <= '0;
         pair_cnt <= 7'h00;
         tenth_cnt <= 4'h0;
         samp_idx <= '0;
      end else if (sample_en) begin
         samp_idx <= frame_last ? '0 : samp_idx + 1'b1;
         samp_in_pair <= pair_last ? '0 : samp_in_pair + 1'b1;
         if (pair_last) begin
            pair_cnt <= (pair_cnt == 7'(PAIRS_PER_TENTH - 1)) ? 7'h00 : pair_cnt + 7'h01;
            if (pair_cnt == 7'(PAIRS_PER_TENTH - 1)) begin
               tenth_cnt <= (tenth_cnt == 4'(TENTHS_PER_FRAME - 1)) ? 4'h0 : tenth_cnt + 4'h1;
            end
         end
      end
   end

   assign tenth_first = sample_en && samp_in_pair == '0 && pair_cnt == 7'h00;
   assign frame_first = tenth_first && tenth_cnt == 4'h0;
   assign pair_last = sample_en && samp_in_pair == PAIR_CW'(SAMPLES_PER_PAIR_P - 1);
   assign frame_last = pair_last && pair_cnt == 7'(PAIRS_PER_TENTH - 1) &&
                       tenth_cnt == 4'(TENTHS_PER_FRAME - 1);

   // Selection held for the whole frame
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         frame_select <= SELECT_RESET;
      end else if (go || frame_last) begin
         frame_select <= ctrl_select;
      end
   end

   test_signal_source #(.ADC_W(ADC_W)) u_source (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .restart_in(go),
      .step_in(sample_en),
      .select_in(frame_select),
      .sample_index_in(samp_idx),
      .adc_sample_in(adc_sync),
      .sample_out(sample)
   );

   iq_downconverter #(.SAMPLES_PER_PAIR_P(SAMPLES_PER_PAIR_P)) u_downconv (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .restart_in(go),
      .step_in(sample_en),
      .phase_in(samp_idx[1:0]),
      .dump_in(pair_last),
      .sample_in(sample),
      .i_out(dc_i),
      .q_out(dc_q),
      .pair_valid_out(dc_valid)
   );

   assign square = 32'(sample * sample);

   // Sum of squares, restarted at frame start
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rad_acc <= 40'h0000000000;
      end else if (go) begin
         rad_acc <= 40'h0000000000;
      end else if (sample_en) begin
         rad_acc <= frame_first ? 40'(square) : rad_acc + 40'(square);
      end
   end

   // Snapshots at each tenth, frame start included
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rad_snap <= 40'h0000000000;
         tag_snap <= 24'h000000;
         tag_cnt <= 24'h000000;
         snap_count <= 4'h0;
         frame_count <= 32'h00000000;
      end else if (go) begin
         tag_cnt <= 24'h000000;
         snap_count <= 4'h0;
      end else if (tenth_first) begin
         rad_snap <= rad_acc;
         tag_snap <= tag_cnt;
         tag_cnt <= tag_cnt + 24'h000001;
         snap_count <= frame_first ? 4'h1 : snap_count + 4'h1;
         if (frame_first) begin
            frame_count <= frame_count + 32'h00000001;
         end
      end
   end

   // Latest I/Q pair awaiting output; a new pair wins over the clear
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pair_full <= 1'b0;
         pair_i <= 16'sh0000;
         pair_q <= 16'sh0000;
      end else if (!running) begin
         pair_full <= 1'b0;
      end else if (dc_valid) begin
         pair_full <= 1'b1;
         pair_i <= dc_i;
         pair_q <= dc_q;
      end else if (frame_valid_next_iq_done()) begin
         pair_full <= 1'b0;
      end
   end

   function automatic logic frame_valid_next_iq_done();
      return em_active && !frame_first && is_iq && pair_full && iq_byte == 2'h3;
   endfunction

   always_comb begin
      rel = 9'(off - 9'(RAD_POS));
      slot = 3'(rel / 9'h003);
      is_id = (blk == 4'h0) && (off == 9'(ID_POS));
      is_status = (blk == 4'h0) && (off == 9'(STATUS_POS));
      // Radiometry from byte 6, stride 3
      // Tag from byte 21, stride 3
      is_rt = (off >= 9'(RAD_POS)) && (off <= 9'(TAG_POS + (TAG_BYTES - 1) * FIELD_STRIDE)) &&
              (rel % 9'h003 == 9'h000);
      is_iq = !is_id && !is_status && !is_rt;
      block_end = (blk == 4'(TENTHS_PER_FRAME - 1)) ? (off == 9'(LAST_BLOCK_BYTES - 1)) :
                  (off == 9'(BLOCK_BYTES - 1));
   end

   always_comb begin
      unique case (iq_byte)
         2'h0: iq_mux = pair_i[15:8];
         2'h1: iq_mux = pair_i[7:0];
         2'h2: iq_mux = pair_q[15:8];
         2'h3: iq_mux = pair_q[7:0];
      endcase
      byte_ready = pair_full;
      byte_mux = iq_mux;
      if (is_id) begin
         byte_mux = FRAME_ID;
         byte_ready = 1'b1;
      end else if (is_status) begin
         byte_mux = 8'(frame_select) << STATUS_SEL_LSB;
         byte_ready = 1'b1;
      end else if (is_rt) begin
         byte_ready = (snap_count > blk);
         if (slot < 3'(RAD_BYTES)) begin
            byte_mux = 8'(rad_snap >> {3'(RAD_BYTES - 1) - slot, 3'h0});
         end else begin
            byte_mux = 8'(tag_snap >> {3'(RT_SLOTS - 1) - slot, 3'h0});
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         em_active <= 1'b0;
         blk <= 4'h0;
         off <= 9'h000;
         iq_byte <= 2'h0;
         frame_data_out <= 8'h00;
         frame_valid_out <= 1'b0;
         frame_first_out <= 1'b0;
      end else begin
         frame_valid_out <= 1'b0;
         frame_first_out <= 1'b0;
         if (!running || !ctrl_enable) begin
            em_active <= 1'b0;
         end else if (frame_first) begin
            em_active <= 1'b1;
            blk <= 4'h0;
            off <= 9'h000;
            iq_byte <= 2'h0;
         end else if (em_active && byte_ready) begin
            frame_valid_out <= 1'b1;
            frame_data_out <= byte_mux;
            frame_first_out <= is_id;
            if (is_iq) begin
               iq_byte <= iq_byte + 2'h1;
            end
            // 9 x 508 + 510 bytes per frame
            if (block_end) begin
               off <= 9'h000;
               if (blk == 4'(TENTHS_PER_FRAME - 1)) begin
                  em_active <= 1'b0;
               end else begin
                  blk <= blk + 4'h1;
               end
            end else begin
               off <= off + 9'h001;
            end
         end
      end
   end
endmodule

// >>> rtl/iq_downconverter.sv
// Quarter-rate mixer to baseband with integrate-and-dump filters
module iq_downconverter
   import frame_pkg::*;
#(
   parameter int SAMPLES_PER_PAIR_P = SAMPLES_PER_PAIR
)(
   input wire logic clk_in,                 // System clock
   input wire logic rst_in,                 // Async reset, high
   input wire logic restart_in,             // Start of a run
   input wire logic step_in,                // Sample enable
   input wire logic [1:0] phase_in,         // Mixer phase, sample index mod 4
   input wire logic dump_in,                // Last sample of a pair period
   input wire logic signed [15:0] sample_in, // Input sample
   output logic signed [15:0] i_out,        // In-phase value
   output logic signed [15:0] q_out,        // Quadrature value
   output logic pair_valid_out              // One-cycle pair strobe
);
   localparam int ACC_W = 17 + $clog2(SAMPLES_PER_PAIR_P);
   logic signed [ACC_W-1:0] i_acc, q_acc, next_i, next_q, ext;

   // Mix by fs/4 then boxcar filter
   always_comb begin
      ext = ACC_W'(sample_in);
      next_i = i_acc;
      next_q = q_acc;
      unique case (phase_in)
         2'h0: next_i = i_acc + ext;
         2'h1: next_q = q_acc - ext;
         2'h2: next_i = i_acc - ext;
         2'h3: next_q = q_acc + ext;
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         i_acc <= '0;
         q_acc <= '0;
         i_out <= 16'sh0000;
         q_out <= 16'sh0000;
         pair_valid_out <= 1'b0;
      end else begin
         pair_valid_out <= 1'b0;
         if (restart_in) begin
            i_acc <= '0;
            q_acc <= '0;
         end else if (step_in && dump_in) begin
            i_out <= next_i[ACC_W-1 -: 16];
            q_out <= next_q[ACC_W-1 -: 16];
            pair_valid_out <= 1'b1;
            i_acc <= '0;
            q_acc <= '0;
         end else if (step_in) begin
            i_acc <= next_i;
            q_acc <= next_q;
         end
      end
   end
endmodule

// >>> rtl/test_signal_source.sv
// Input selector: converter samples or one of the built-in test signals
module test_signal_source
   import frame_pkg::*;
#(
   parameter int ADC_W = ADC_WIDTH
)(
   input wire logic clk_in,                          // System clock
   input wire logic rst_in,                          // Async reset, high
   input wire logic restart_in,                      // Start of a run
   input wire logic step_in,                         // Sample enable
   input wire logic [2:0] select_in,                 // Input selection
   input wire logic [SAMPLE_IDX_W-1:0] sample_index_in, // Sample index in frame
   input wire logic [ADC_W-1:0] adc_sample_in,       // Synchronised converter word
   output logic signed [15:0] sample_out             // Selected sample
);
   logic [LFSR_W-1:0] lfsr;
   logic signed [15:0] full_pos;

   assign full_pos = 16'((32'sd1 <<< (ADC_W - 1)) - 32'sd1);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         lfsr <= LFSR_SEED;
      end else if (restart_in) begin
         lfsr <= LFSR_SEED;
      end else if (step_in) begin
         lfsr <= {lfsr[LFSR_W-2:0], lfsr[LFSR_W-1] ^ lfsr[LFSR_TAP]};
      end
   end

   always_comb begin
      unique case (select_t'(select_in))
         SEL_ADC: sample_out = 16'($signed(adc_sample_in));
         SEL_ZERO: sample_out = 16'sh0000;
         SEL_IMPULSE: sample_out = (sample_index_in < SAMPLE_IDX_W'(IMPULSE_LEN)) ? IMPULSE_VALUE : 16'sh0000;
         SEL_SQ_LOW: sample_out = sample_index_in[SQ_LOW_BIT] ? -SQUARE_AMPL : SQUARE_AMPL;
         SEL_SQ_MID: sample_out = sample_index_in[SQ_MID_BIT] ? -SQUARE_AMPL : SQUARE_AMPL;
         SEL_SQ_HIGH: sample_out = sample_index_in[SQ_HIGH_BIT] ? -SQUARE_AMPL : SQUARE_AMPL;
         SEL_PRN_UNIT: sample_out = lfsr[0] ? 16'sh0001 : -16'sh0001;
         SEL_PRN_FULL: sample_out = lfsr[0] ? full_pos : -full_pos - 16'sh0001;
      endcase
   end
endmodule

// >>> testbench/frame_generator_asserts.sv
// Checker for frame generator output timing and layout
module frame_generator_asserts
   import frame_pkg::*;
#(
   parameter int SAMPLES_PER_PAIR_P = SAMPLES_PER_PAIR
)(
   input wire logic clk_in, // Clock
   input wire logic rst_in, // Reset
   input wire logic second_pulse_strobe_in, // Strobe
   input wire logic [7:0] frame_data_out, // Byte
   input wire logic frame_valid_out, // Byte strobe
   input wire logic frame_first_out, // Frame start
   input wire logic running_out // Running
);
   localparam int PERIOD = SAMPLES_PER_PAIR_P * PAIRS_PER_TENTH * TENTHS_PER_FRAME * SAMPLE_DIV;
   logic [3:0] age;
   logic [12:0] cnt;
   logic [31:0] cyc;
   logic seen;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // Cycles since strobe
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) age <= 4'hF;
      else if (second_pulse_strobe_in) age <= 4'h0;
      else if (age != 4'hF) age <= age + 4'h1;
   end
   // Bytes and cycles since frame start
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt <= 13'h0;
         cyc <= 32'h0;
         seen <= 1'h0;
      end else begin
         if (frame_valid_out) cnt <= frame_first_out ? 13'h1 : cnt + 13'h1;
         cyc <= (frame_valid_out && frame_first_out) ? 32'h1 : cyc + 32'h1;
         if (frame_valid_out && frame_first_out) seen <= 1'h1;
      end
   end
   property p_id; frame_first_out |-> frame_data_out == FRAME_ID; endproperty
   a_id: assert property (p_id) else $error("first byte not B7");
   property p_strobe; frame_first_out |-> frame_valid_out ##1 !frame_first_out; endproperty
   a_strobe: assert property (p_strobe) else $error("first strobe malformed");
   property p_run; frame_valid_out |-> running_out; endproperty
   a_run: assert property (p_run) else $error("byte while stopped");
   property p_start; $rose(running_out) |-> age < 4'hA; endproperty
   a_start: assert property (p_start) else $error("start without strobe");
   property p_lead; $rose(running_out) |-> !frame_valid_out [*8] ##[10:40] frame_first_out; endproperty
   a_lead: assert property (p_lead) else $error("frame start late");
   property p_len; frame_first_out && cnt != 13'h0 |-> cnt == 13'(FRAME_BYTES); endproperty
   a_len: assert property (p_len) else $error("frame length wrong");
   property p_period; frame_first_out && seen |-> cyc == 32'(PERIOD); endproperty
   a_period: assert property (p_period) else $error("frame period wrong");
   property p_status; frame_valid_out && cnt == 13'h3 |-> frame_data_out[7] == 1'h0 && frame_data_out[3:0] == 4'h0;
   endproperty
   a_status: assert property (p_status) else $error("status spare bits set");
endmodule

bind frame_generator frame_generator_asserts #(.SAMPLES_PER_PAIR_P(SAMPLES_PER_PAIR_P)) frame_generator_asserts_i (
   .clk_in, .rst_in, .second_pulse_strobe_in, .frame_data_out, .frame_valid_out, .frame_first_out, .running_out);

// >>> testbench/frame_generator_tb.sv
// Self-checking bench for the frame generator
module frame_generator_tb
   import frame_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(n, e, g) begin \
   cmp_count++; \
   if ((g) !== (e)) begin \
      errors++; \
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
   end \
end
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pps = 0, prdy, perr, vld, fst, run, er;
   logic [7:0] paddr = 8'h0, dat;
   logic [31:0] pwd = 32'h0, prd, rd;
   logic [ADC_WIDTH-1:0] adc;
   int errors = 0, cmp_count = 0, rec_idx, rec_frames;
   frame_generator #(.SAMPLES_PER_PAIR_P(2)) frame_generator_i (.clk_in(clk), .rst_in(rst), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
      .pslverr_out(perr), .second_pulse_strobe_in(pps), .adc_data_in(adc), .frame_data_out(dat),
      .frame_valid_out(vld), .frame_first_out(fst), .running_out(run));
   frame_recorder_model frame_recorder_model_i (.clk_in(clk), .rst_in(rst), .frame_data_in(dat),
      .frame_valid_in(vld), .frame_first_in(fst), .adc_data_out(adc), .idx_out(rec_idx), .frames_out(rec_frames));
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic complete_run();
      if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic timeout_hit();
      errors++;
      complete_run();
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'h1;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'h1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (prdy !== 1'h1 && n < 20);
      rd = prd;
      er = perr;
      psel <= 1'h0;
      pen <= 1'h0;
      if (prdy !== 1'h1) timeout_hit();
      @(posedge clk);
   endtask
   task automatic pulse();
      pps <= 1'h1;
      repeat (8) @(posedge clk);
      pps <= 1'h0;
   endtask
   task automatic wait_rec(input int f, input int n, input int lim);
      int c;
      c = 0;
      while (!(rec_frames == f && rec_idx > n) && c < lim) begin
         @(posedge clk);
         c++;
      end
      if (c >= lim) timeout_hit();
   endtask
   function automatic logic [39:0] field(input int p, input int nb);
      logic [39:0] v;
      v = 40'h0;
      for (int j = 0; j < nb; j++) v = {v[31:0], frame_recorder_model_i.mem[p + 3 * j]};
      return v;
   endfunction
   task automatic t_regs();
      apb(1'h0, CTRL_ADDR, 32'h0);
      `CHK("ctrl reset", 32'h0, rd)
      apb(1'h0, 8'h10, 32'h0);
      `CHK("unmapped err", 1'h1, er)
   endtask
   task automatic t_start();
      pulse();
      repeat (30) @(posedge clk);
      `CHK("idle run", 1'h0, run)
      apb(1'h1, CTRL_ADDR, 32'h11);
      apb(1'h0, STATUS_ADDR, 32'h0);
      `CHK("armed", 32'h2, rd)
      pulse();
      wait_rec(1, 0, 300);
      `CHK("running", 1'h1, run)
   endtask
   task automatic t_frame1();
      apb(1'h1, CTRL_ADDR, 32'h71);
      wait_rec(1, FRAME_BYTES - 1, 70000);
      `CHK("id", FRAME_ID, frame_recorder_model_i.mem[0])
      `CHK("status", 8'h10, frame_recorder_model_i.mem[3])
      `CHK("pair2", 40'h0, field(7, 1) | field(8, 1) | field(10, 1) | field(11, 1))
      for (int k = 0; k < 10; k++) begin
         `CHK("rad", (k == 0) ? 40'h0 : 40'h8000, field(BLOCK_BYTES * k + RAD_POS, RAD_BYTES))
         `CHK("tag", 40'(k), field(BLOCK_BYTES * k + TAG_POS, TAG_BYTES))
      end
   endtask
   task automatic t_frame2();
      wait_rec(2, 28, 3000);
      `CHK("status2", 8'h70, frame_recorder_model_i.mem[3])
      `CHK("rad full", 40'h8000, field(RAD_POS, RAD_BYTES))
      `CHK("tag cont", 40'hA, field(TAG_POS, TAG_BYTES))
      `CHK("zero iq", 40'h0, field(1, 2) | field(4, 2))
   endtask
   task automatic t_stop();
      apb(1'h0, FRAMES_ADDR, 32'h0);
      `CHK("frames", 32'h2, rd)
      apb(1'h1, CTRL_ADDR, 32'h0);
      repeat (5) @(posedge clk);
      `CHK("stopped", 1'h0, run)
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      t_regs();
      t_start();
      t_frame1();
      t_frame2();
      t_stop();
      complete_run();
   end
endmodule

// >>> testbench/frame_recorder_model.sv
// Recorder and converter stand-in at the frame generator's far side
module frame_recorder_model
   import frame_pkg::*;
(
   input wire logic clk_in, // Clock
   input wire logic rst_in, // Reset
   input wire logic [7:0] frame_data_in, // Byte
   input wire logic frame_valid_in, // Byte strobe
   input wire logic frame_first_in, // Frame start
   output logic [ADC_WIDTH-1:0] adc_data_out, // Converter word
   output int idx_out, // Bytes of frame
   output int frames_out // Frames seen
);
   logic [7:0] mem [FRAME_BYTES];
   int div;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         div <= 0;
         adc_data_out <= '0;
      end else begin
         div <= (div == SAMPLE_DIV - 1) ? 0 : div + 1;
         if (div == 0) adc_data_out <= ~adc_data_out + 12'h123;
      end
   end
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         idx_out <= 0;
         frames_out <= 0;
      end else if (frame_valid_in) begin
         idx_out <= frame_first_in ? 1 : idx_out + 1;
         frames_out <= frames_out + int'(frame_first_in);
      end
   end
   always_ff @(posedge clk_in) begin
      if (frame_valid_in) mem[frame_first_in ? 0 : idx_out] <= frame_data_in;
   end
endmodule
